// ### adc_pd_pkg.sv
// shared constants and types for the adc power-down control logic
package adc_pd_pkg;

   // register offsets on the control port
   localparam logic [7:0] OFS_POWER_MODE = 8'h06;
   localparam logic [7:0] OFS_GAIN_1A = 8'h2B;
   localparam logic [7:0] OFS_GAIN_1B = 8'h2C;
   localparam logic [7:0] OFS_GAIN_2A = 8'h33;
   localparam logic [7:0] OFS_GAIN_2B = 8'h34;
   localparam logic [7:0] OFS_EVENT = 8'h36;

   // power_mode_control field positions, msb downward
   localparam int PWR_ULTRALOW_BIT = 7;
   localparam int PWR_LOW_BIT = 6;
   localparam int PWR_CLAMP_BIT = 5;
   localparam int PWR_THERM_OFF_BIT = 4;
   localparam logic [7:0] PWR_RESERVED_MASK = 8'h0F;

   // event_flags field positions
   localparam int EV_SLEEP_DONE = 7;
   localparam int EV_THERM_TRIP = 6;
   localparam int EV_SYNC_DONE = 5;
   localparam int EV_OVR_2B = 4;
   localparam int EV_OVR_2A = 3;
   localparam int EV_OVR_1B = 2;
   localparam int EV_OVR_1A = 1;
   localparam int EV_MUTE_PIN = 0;

   // codes and reset values
   localparam logic [7:0] MUTE_CODE = 8'h80;
   localparam logic [7:0] RST_POWER_MODE = 8'h00;
   localparam logic [7:0] RST_GAIN = 8'h00;
   localparam logic [7:0] RST_EVENT = 8'h00;
   localparam logic [7:0] RST_READ_DATA = 8'h00;

   // time for the analog core to wind down after a sleep request
   localparam int CLK_PERIOD_NS = 8;
   localparam int SLEEP_SETTLE_NS = 2000;
   localparam int SLEEP_SETTLE_CYC =
      (SLEEP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // one access on the control port
   typedef struct packed
   {
      logic [7:0] addr;   // register offset
      logic [7:0] wdata;  // write value
      logic wr;           // write strobe
      logic rd;           // read strobe
   } reg_req_t;

   // answer to a read
   typedef struct packed
   {
      logic [7:0] data;   // read value
      logic valid;        // one-cycle pulse
   } reg_rsp_t;

   typedef enum logic [1:0] {AWAKE, DRAINING, ASLEEP} sleep_state_t;

   // channel index of a gain register, bit 2 set when the offset is a gain
   function automatic logic [2:0] gain_index(input logic [7:0] addr);
      case (addr)
         OFS_GAIN_1A: gain_index = 3'h4;
         OFS_GAIN_1B: gain_index = 3'h5;
         OFS_GAIN_2A: gain_index = 3'h6;
         OFS_GAIN_2B: gain_index = 3'h7;
         default: gain_index = 3'h0;
      endcase
   endfunction : gain_index

endpackage : adc_pd_pkg

// ### sleep_timer.sv
// wind-down timer: reports the core asleep once a request has settled
`timescale 1ns/1ps
module sleep_timer
   import adc_pd_pkg::*;
#(
   parameter int SETTLE = SLEEP_SETTLE_CYC
)
(
   input wire logic clk,        // system clock
   input wire logic rstn,       // async reset, active low
   input wire logic sleep_req,  // a power-down request bit is set
   output logic asleep          // analog core has powered down
);

   typedef struct packed
   {
      sleep_state_t st;   // wind-down phase
      logic [15:0] cnt;   // settle cycles spent
      logic asleep;       // completion level
   } timer_state_t;

   timer_state_t s;
   timer_state_t next_s;
   logic [15:0] held;   // helper: cycles the request has been held

   // phase walk; dropping the request at any point wakes the core
   always_comb
   begin
      next_s = s;
      case (s.st)
         AWAKE:
         begin
            next_s.cnt = 16'h0000;
            if (sleep_req)
               next_s.st = DRAINING;
         end
         DRAINING:
         begin
            if (!sleep_req)
               next_s.st = AWAKE;
            else if (s.cnt == 16'(SETTLE - 1))
            begin
               next_s.st = ASLEEP;   // only now is it fully down
               next_s.asleep = 1'b1;
            end
            else
               next_s.cnt = s.cnt + 16'h0001;
         end
         ASLEEP:
         begin
            if (!sleep_req)
            begin
               next_s.st = AWAKE;
               next_s.asleep = 1'b0;
            end
         end
         default: next_s.st = AWAKE;
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         s <= '{st: AWAKE, cnt: 16'h0000, asleep: 1'b0};
      else
         s <= next_s;
   end

   assign asleep = s.asleep;

   // helper count for the settle check
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         held <= 16'h0000;
      else if (!sleep_req)
         held <= 16'h0000;
      else if (held != 16'hFFFF)
         held <= held + 16'h0001;
   end

   a_settle_time: assert property (
      @(posedge clk) disable iff (!rstn)
      $rose(asleep) |-> held >= 16'(SETTLE))
      else $error("asleep rose before the settle time");

endmodule : sleep_timer

// ### adc_power_down_sequencer.sv
// power-down control, channel mute and event flags of the quad adc
`timescale 1ns/1ps
// Contract
// - gain code 0x80 mutes that channel output
// - reading event_flags clears the completion flag
// - power control bits ulp, lp, clamp, thermal
// - completion flag sets only when fully down
// - flags report thermal, sync, overrange, mute pin
// - writing 0xB0 clamps the filter capacitor pin
module adc_power_down_sequencer
   import adc_pd_pkg::*;
#(
   parameter int SAMPLE_W = 24,             // audio word width
   parameter int SETTLE = SLEEP_SETTLE_CYC  // wind-down cycles
)
(
   input wire logic clk,                    // 125 mhz system clock
   input wire logic rstn,                   // async reset, active low
   input reg_req_t reg_req,                 // control port access
   output reg_rsp_t reg_rsp,                // read answer
   input wire logic thermal_trip_in,        // thermal sense tripped
   input wire logic sync_done_in,           // multichip sync finished
   input wire logic [3:0] overrange_in,     // 1a,1b,2a,2b overrange
   input wire logic mute_pin_in,            // mute pin asserted
   input wire logic sample_valid_in,        // new sample on all channels
   input wire logic [3:0][SAMPLE_W-1:0] sample_in,    // decimator data
   output logic sample_valid_out,           // registered sample strobe
   output logic [3:0][SAMPLE_W-1:0] sample_out,       // channel data
   output logic filter_cap_clamp,           // filter_cap_pin to ground
   output logic thermal_sense_en,           // thermal sense powered
   output logic core_powered                // analog core running
);

   typedef struct packed
   {
      logic [3:0][7:0] gain;               // 1a,1b,2a,2b gain codes
      logic [7:0] power_mode;              // power_mode_control
      logic [7:0] flags;                   // event_flags
      reg_rsp_t rsp;                       // read answer
      logic asleep_q;                      // completion seen last cycle
      logic valid_o;                       // sample strobe out
      logic [3:0][SAMPLE_W-1:0] data_o;    // sample data out
      logic clamp_o;                       // clamp drive
      logic therm_o;                       // thermal sense enable
      logic core_o;                        // core power enable
   } core_state_t;

   core_state_t s;
   core_state_t next_s;
   logic asleep;          // timer says the device is down
   logic sleep_req;       // either power-down request bit
   logic [7:0] set_vec;   // events arriving this cycle
   logic status_read;     // this cycle reads event_flags
   logic [2:0] gidx;      // decoded gain register

   assign sleep_req = s.power_mode[PWR_ULTRALOW_BIT] |
                      s.power_mode[PWR_LOW_BIT];

   // wind-down timing lives apart so its count can be shortened
   sleep_timer #(
      .SETTLE(SETTLE)
   ) sleep_timer_inst (
      .clk(clk),
      .rstn(rstn),
      .sleep_req(sleep_req),
      .asleep(asleep)
   );

   assign gidx = gain_index(reg_req.addr);
   assign status_read = reg_req.rd && (reg_req.addr == OFS_EVENT);

   // event sources, sampled as level each cycle; completion as a rising edge
   always_comb
   begin
      set_vec = 8'h00;
      set_vec[EV_SLEEP_DONE] = asleep & ~s.asleep_q;  // rising edge
      set_vec[EV_THERM_TRIP] = thermal_trip_in;
      set_vec[EV_SYNC_DONE] = sync_done_in;
      set_vec[EV_OVR_1A] = overrange_in[0];
      set_vec[EV_OVR_1B] = overrange_in[1];
      set_vec[EV_OVR_2A] = overrange_in[2];
      set_vec[EV_OVR_2B] = overrange_in[3];
      set_vec[EV_MUTE_PIN] = mute_pin_in;
   end

   // register writes, reads, flags and the data path
   always_comb
   begin
      next_s = s;
      next_s.asleep_q = asleep;
      next_s.rsp.valid = 1'b0;
      // writes; reserved power bits are never stored
      if (reg_req.wr)
      begin
         if (reg_req.addr == OFS_POWER_MODE)
            next_s.power_mode = reg_req.wdata & ~PWR_RESERVED_MASK;
         else if (gidx[2])
            next_s.gain[gidx[1:0]] = reg_req.wdata;
      end
      // reads answer one cycle later; unmapped offsets read zero
      if (reg_req.rd)
      begin
         next_s.rsp.valid = 1'b1;
         if (reg_req.addr == OFS_POWER_MODE)
            next_s.rsp.data = s.power_mode;
         else if (gidx[2])
            next_s.rsp.data = s.gain[gidx[1:0]];
         else if (status_read)
            next_s.rsp.data = s.flags;
         else
            next_s.rsp.data = RST_READ_DATA;
      end
      // read clears, but a same-cycle event still sets
      next_s.flags = (status_read ? RST_EVENT : s.flags) | set_vec;
      // mute code forces zero; sleeping core outputs zero too
      next_s.valid_o = sample_valid_in & ~asleep;
      if (sample_valid_in)
      begin
         for (int c = 0; c < 4; c++)
            next_s.data_o[c] = (s.gain[c] == MUTE_CODE || asleep) ?
                               '0 : sample_in[c];
      end
      // clamp and thermal drives follow the stored control byte; core power follows the timer
      next_s.clamp_o = next_s.power_mode[PWR_CLAMP_BIT];
      next_s.therm_o = ~next_s.power_mode[PWR_THERM_OFF_BIT];
      next_s.core_o = ~asleep;
   end

   // state register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s <= '0;
         s.gain <= {4{RST_GAIN}};
         s.power_mode <= RST_POWER_MODE;
         s.flags <= RST_EVENT;
         s.therm_o <= ~RST_POWER_MODE[PWR_THERM_OFF_BIT];
         s.core_o <= 1'b1;
      end
      else
         s <= next_s;
   end

   assign reg_rsp = s.rsp;
   assign sample_valid_out = s.valid_o;
   assign sample_out = s.data_o;
   assign filter_cap_clamp = s.clamp_o;
   assign thermal_sense_en = s.therm_o;
   assign core_powered = s.core_o;

   a_mute_zero: assert property (
      @(posedge clk) disable iff (!rstn)
      sample_valid_in && s.gain[0] == MUTE_CODE |=> sample_out[0] == '0)
      else $error("muted channel passed data");

   a_read_clears: assert property (
      @(posedge clk) disable iff (!rstn)
      status_read && set_vec == 8'h00 |=> s.flags == 8'h00)
      else $error("status read did not clear flags");

   a_read_answer: assert property (
      @(posedge clk) disable iff (!rstn)
      status_read |=> reg_rsp.valid && reg_rsp.data == $past(s.flags))
      else $error("status read answered wrong");

   a_reserved_zero: assert property (
      @(posedge clk) disable iff (!rstn)
      (s.power_mode & PWR_RESERVED_MASK) == 8'h00)
      else $error("reserved power bits set");

   a_done_when_down: assert property (
      @(posedge clk) disable iff (!rstn)
      $rose(s.flags[EV_SLEEP_DONE]) |-> $past(asleep) && sleep_req)
      else $error("completion flag without power down");

   a_done_sticky: assert property (
      @(posedge clk) disable iff (!rstn)
      s.flags[EV_SLEEP_DONE] && !status_read |=> s.flags[EV_SLEEP_DONE])
      else $error("completion flag dropped without a read");

   a_overrange_seen: assert property (
      @(posedge clk) disable iff (!rstn)
      overrange_in[0] ##1 !status_read |=> s.flags[EV_OVR_1A])
      else $error("overrange event lost");

   a_clamp_follows: assert property (
      @(posedge clk) disable iff (!rstn)
      reg_req.wr && reg_req.addr == OFS_POWER_MODE
      |=> filter_cap_clamp == $past(reg_req.wdata[PWR_CLAMP_BIT]))
      else $error("clamp pin did not follow control write");

   // thermal sense must power off with bit 4 of the control byte
   a_therm_follows: assert property (
      @(posedge clk) disable iff (!rstn)
      reg_req.wr && reg_req.addr == OFS_POWER_MODE
      |=> thermal_sense_en == !$past(reg_req.wdata[PWR_THERM_OFF_BIT]))
      else $error("thermal sense enable did not follow control write");

   // the last channel is guarded too, so an index slip shows up
   a_mute_last: assert property (
      @(posedge clk) disable iff (!rstn)
      sample_valid_in && s.gain[3] == MUTE_CODE |=> sample_out[3] == '0)
      else $error("muted channel 2b passed data");

   // core power and completion flag change on the same edge
   a_core_down_flag: assert property (
      @(posedge clk) disable iff (!rstn)
      $fell(core_powered) |-> s.flags[EV_SLEEP_DONE])
      else $error("core powered down without completion flag");

   // a sleeping core must not emit sample strobes
   a_sleep_silent: assert property (
      @(posedge clk) disable iff (!rstn)
      !core_powered |-> !sample_valid_out)
      else $error("sample strobe while the core is down");

   // a thermal trip is latched even with the sense circuit off
   a_trip_seen: assert property (
      @(posedge clk) disable iff (!rstn)
      thermal_trip_in |=> s.flags[EV_THERM_TRIP])
      else $error("thermal trip event lost");

endmodule : adc_power_down_sequencer

// ### host_ctrl_model.sv
// host controller model that drives the control port
`timescale 1ns/1ps
module host_ctrl_model
   import adc_pd_pkg::*;
(
   input wire logic clk,     // system clock
   output reg_req_t reg_req, // access request
   input reg_rsp_t reg_rsp   // read answer
);

   // strobes idle from time zero
   initial reg_req = '0;

   // one write: strobe up off a falling edge, down one cycle later
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(negedge clk);
      reg_req.wr = 1'b0;
   endtask : reg_write

   // one read; the answer is caught while valid stands, bounded wait
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      int n;
      @(negedge clk);
      reg_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(negedge clk);
      reg_req.rd = 1'b0;
      for (n = 0; n < 3 && reg_rsp.valid !== 1'b1; n++)
         @(negedge clk);
      d = (reg_rsp.valid === 1'b1) ? reg_rsp.data : 8'hXX;
   endtask : reg_read

   // mute every channel, flush stale status, then ask for ultralow sleep
   task automatic sleep_request();
      logic [7:0] d;
      reg_write(OFS_GAIN_1A, MUTE_CODE);
      reg_write(OFS_GAIN_1B, MUTE_CODE);
      reg_write(OFS_GAIN_2A, MUTE_CODE);
      reg_write(OFS_GAIN_2B, MUTE_CODE);
      reg_read(OFS_EVENT, d);
      reg_write(OFS_POWER_MODE, 8'h90);
   endtask : sleep_request

   // poll status until completion shows; gives up after 100 reads
   task automatic poll_done(output logic [7:0] d);
      int n;
      d = 8'h00;
      for (n = 0; n < 100 && d[EV_SLEEP_DONE] !== 1'b1; n++)
         reg_read(OFS_EVENT, d);
   endtask : poll_done

   // optional discharge of the filter capacitor once asleep
   task automatic discharge();
      reg_write(OFS_POWER_MODE, 8'hB0);
   endtask : discharge

endmodule : host_ctrl_model

// ### tb_top.sv
// self-checking bench for the adc power-down control logic
`timescale 1ns/1ps
module tb_top;
   import adc_pd_pkg::*;

   localparam int SET = 4; // shortened wind-down keeps the run brief
   logic clk; // system clock
   logic rstn; // async reset, active low
   reg_req_t reg_req;
   reg_rsp_t reg_rsp;
   logic thermal_trip_in;
   logic sync_done_in;
   logic mute_pin_in;
   logic sample_valid_in;
   logic [3:0] overrange_in;
   logic [3:0][23:0] sample_in;
   logic [3:0][23:0] sample_out;
   logic sample_valid_out;
   logic filter_cap_clamp;
   logic thermal_sense_en;
   logic core_powered;
   int num_errors = 0;
   int comparisons = 0;
   logic [7:0] d;

   adc_power_down_sequencer #(.SAMPLE_W(24), .SETTLE(SET))
      adc_power_down_sequencer_inst (.clk(clk), .rstn(rstn),
      .reg_req(reg_req), .reg_rsp(reg_rsp),
      .thermal_trip_in(thermal_trip_in), .sync_done_in(sync_done_in),
      .overrange_in(overrange_in), .mute_pin_in(mute_pin_in),
      .sample_valid_in(sample_valid_in), .sample_in(sample_in),
      .sample_valid_out(sample_valid_out), .sample_out(sample_out),
      .filter_cap_clamp(filter_cap_clamp),
      .thermal_sense_en(thermal_sense_en), .core_powered(core_powered));

   host_ctrl_model host_ctrl_model_inst (.clk(clk), .reg_req(reg_req),
      .reg_rsp(reg_rsp));

   // 125 mhz clock
   always #4 clk = ~clk;

   // compare, count, report a mismatch at once
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check

   // read one register and compare
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      host_ctrl_model_inst.reg_read(a, d);
      check(d, exp);
   endtask : rd_chk

   // one sample strobe; output strobe is looked at while it stands
   task automatic send_sample(input logic exp_valid);
      @(negedge clk);
      sample_in = {24'h444444, 24'h333333, 24'h222222, 24'h111111};
      sample_valid_in = 1'b1;
      @(negedge clk);
      sample_valid_in = 1'b0;
      check(sample_valid_out, exp_valid);
   endtask : send_sample

   // reset values, reserved bits, unmapped offset
   task automatic test_reset();
      check(core_powered, 1'b1);
      check(thermal_sense_en, 1'b1);
      rd_chk(OFS_GAIN_2B, RST_GAIN);
      host_ctrl_model_inst.reg_write(OFS_POWER_MODE, 8'h0F);
      rd_chk(OFS_POWER_MODE, 8'h00);
      rd_chk(8'h07, 8'h00);
   endtask : test_reset

   // mute code silences only its channel; other codes pass data
   task automatic test_mute();
      host_ctrl_model_inst.reg_write(OFS_GAIN_1A, MUTE_CODE);
      host_ctrl_model_inst.reg_write(OFS_GAIN_2A, 8'h7F);
      rd_chk(OFS_GAIN_1A, MUTE_CODE);
      send_sample(1'b1);
      check(sample_out[0], 24'h000000);
      check(sample_out[1], 24'h222222);
      check(sample_out[2], 24'h333333);
      check(sample_out[3], 24'h444444);
   endtask : test_mute

   // low request alone also powers down; an early drop aborts it
   task automatic test_low_sleep();
      host_ctrl_model_inst.reg_write(OFS_POWER_MODE, 8'h40);
      repeat (20) @(negedge clk);
      check(core_powered, 1'b0);
      check(thermal_sense_en, 1'b1);
      host_ctrl_model_inst.reg_write(OFS_POWER_MODE, 8'h00);
      @(negedge clk);
      rd_chk(OFS_EVENT, 8'h80);
      check(core_powered, 1'b1);
      host_ctrl_model_inst.reg_write(OFS_POWER_MODE, 8'h40);
      host_ctrl_model_inst.reg_write(OFS_POWER_MODE, 8'h00);
      repeat (20) @(negedge clk);
      rd_chk(OFS_EVENT, 8'h00);
   endtask : test_low_sleep

   // every event input pin lands in its own flag; a read clears them
   task automatic test_events();
      int i;
      @(negedge clk);
      {thermal_trip_in, sync_done_in, mute_pin_in} = 3'h7;
      @(negedge clk);
      {thermal_trip_in, sync_done_in, mute_pin_in} = 3'h0;
      rd_chk(OFS_EVENT, 8'h61);
      rd_chk(OFS_EVENT, 8'h00);
      for (i = 0; i < 4; i++)
      begin
         @(negedge clk);
         overrange_in = 4'h1 << i;
         @(negedge clk);
         overrange_in = 4'h0;
         rd_chk(OFS_EVENT, 8'h02 << i);
      end
   endtask : test_events

   // full power-down walk, discharge, then reset
   task automatic test_power_down();
      host_ctrl_model_inst.sleep_request();
      rd_chk(OFS_EVENT, 8'h00);
      check(thermal_sense_en, 1'b0);
      check(core_powered, 1'b1);
      repeat (30) @(negedge clk);
      check(core_powered, 1'b0);
      send_sample(1'b0);
      check(sample_out[3], 24'h000000);
      host_ctrl_model_inst.poll_done(d);
      check(d, 8'h80);
      rd_chk(OFS_EVENT, 8'h00);
      host_ctrl_model_inst.discharge();
      @(negedge clk);
      check(filter_cap_clamp, 1'b1);
      rd_chk(OFS_POWER_MODE, 8'hB0);
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      check(filter_cap_clamp, 1'b0);
      check(core_powered, 1'b1);
      rstn = 1'b1;
      rd_chk(OFS_GAIN_1A, RST_GAIN);
   endtask : test_power_down

   // counts, verdict, end of run
   task automatic wrap_up();
      $display("errors %0d, comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up

   // main sequence; inputs change on falling edges
   initial
   begin
      clk = 1'b0;
      rstn = 1'b0;
      {thermal_trip_in, sync_done_in, mute_pin_in} = 3'h0;
      sample_valid_in = 1'b0;
      overrange_in = 4'h0;
      sample_in = '0;
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      test_reset();
      test_mute();
      test_events();
      test_low_sleep();
      test_power_down();
      wrap_up();
   end

   // watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      #(8 * 5000);
      num_errors++;
      wrap_up();
   end

endmodule : tb_top
